// >>> hw/exec_alu.sv
// Purpose: result and flags for shift and subtract
// Assumes: pass op leaves flags as given
// Notes: purely combinational
`timescale 1ns/1ps
module exec_alu (
  exec_if.alu bus
);
  logic [8:0] diff;
  logic [4:0] nib;
  logic is_sub, is_sra;
  // nine-bit subtract of the source, borrow comes out as bit 8
  assign diff = {1'b0, bus.alu_a} - {1'b0, bus.alu_b}; // [RL12]
  assign nib = {1'b0, bus.alu_a[3:0]} - {1'b0, bus.alu_b[3:0]};
  assign is_sub = (bus.alu_op == exec_pkg::ALU_SUB);
  assign is_sra = (bus.alu_op == exec_pkg::ALU_SRA);
  assign bus.alu_res = is_sub ? diff[7:0] : is_sra ? {bus.alu_a[7], bus.alu_a[7:1]} : bus.alu_a; // [RL2]
  // flags, kept unless the op owns them
  assign bus.flags_out[exec_pkg::F_C] = is_sub ? diff[8] : is_sra ? bus.alu_a[0] // [RL3] [RL13]
    : bus.flags_in[exec_pkg::F_C];
  assign bus.flags_out[exec_pkg::F_Z] = (is_sub | is_sra) ? (bus.alu_res == 8'h00) : bus.flags_in[exec_pkg::F_Z];
  assign bus.flags_out[exec_pkg::F_S] = (is_sub | is_sra) ? bus.alu_res[7] : bus.flags_in[exec_pkg::F_S];
  assign bus.flags_out[exec_pkg::F_V] = is_sub ? ((bus.alu_a[7] ^ bus.alu_b[7]) & (bus.alu_res[7] == bus.alu_b[7])) // [RL14]
    : is_sra ? 1'b0 : bus.flags_in[exec_pkg::F_V];
  assign bus.flags_out[exec_pkg::F_D] = is_sub | bus.flags_in[exec_pkg::F_D]; // [RL15]
  assign bus.flags_out[exec_pkg::F_H] = is_sub ? nib[4] : bus.flags_in[exec_pkg::F_H]; // [RL15]
  assign bus.flags_out[exec_pkg::F_H-1:0] = bus.flags_in[exec_pkg::F_H-1:0];
endmodule : exec_alu

// >>> hw/exec_core.sv
// Purpose: executes one instruction written over apb, then reports status
// Assumes: ext_int is asynchronous, apb master on pclk
// Notes: register array is mapped as words at 0x000..0x3fc
`timescale 1ns/1ps
module exec_core (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_int,
  output logic stop_mode,
  output logic cpu_clk_en,
  output logic sys_clk_en
);
  exec_if bus ();
  exec_pkg::state_t state;
  logic [23:0] instr;
  logic [7:0] flags, window_base_first, window_base_second, eff_dst, eff_src;
  logic [2:0] cnt;
  logic illegal, int_meta, int_sync, refuse;

  // working register r0..r7 through the first base, r8..r15 through the second
  function automatic logic [7:0] work_addr(input logic [3:0] r, input logic [7:0] a, input logic [7:0] b);
    work_addr = r[3] ? {b[7:3], r[2:0]} : {a[7:3], r[2:0]};
  endfunction : work_addr

  // a full address in the c0..cf range means a working register
  function automatic logic [7:0] resolve(input logic [7:0] x, input logic [7:0] a, input logic [7:0] b);
    resolve = (x[7:4] == exec_pkg::WORK_NIB) ? work_addr(x[3:0], a, b) : x;
  endfunction : resolve

  // window bases overlay the array at their own addresses
  function automatic logic [7:0] overlay(input logic [7:0] ad, input logic [7:0] m, input logic [7:0] a,
    input logic [7:0] b);
    overlay = (ad == exec_pkg::ADDR_PTR_A) ? a : (ad == exec_pkg::ADDR_PTR_B) ? b : m;
  endfunction : overlay

  exec_regfile exec_regfile_inst (
    .pclk(pclk),
    .bus(bus.mem)
  );
  exec_alu exec_alu_inst (
    .bus(bus.alu)
  );

  // instruction decode
  logic [7:0] op, b1, b2, dst_addr, src_addr, rd_a, rd_b, rd_c, opb;
  logic is_sub, is_sra, dst_ind, src_ind, src_imm, idle, do_exec;
  logic [2:0] ncyc;
  assign op = instr[7:0];
  assign b1 = instr[15:8];
  assign b2 = instr[23:16];
  assign is_sub = (op >= exec_pkg::OP_SUB_RR) && (op <= exec_pkg::OP_SUB_IM);
  assign is_sra = (op == exec_pkg::OP_SHIFT_R) || (op == exec_pkg::OP_SHIFT_IR);
  assign dst_ind = (op == exec_pkg::OP_SHIFT_IR); // [RL16]
  assign src_ind = (op == exec_pkg::OP_SUB_RIR) || (op == exec_pkg::OP_SUB_GI); // [RL16]
  assign src_imm = (op == exec_pkg::OP_SUB_IM);
  assign ncyc = (is_sub && op != exec_pkg::OP_SUB_RR) ? exec_pkg::CYC_LONG : exec_pkg::CYC_SHORT; // [RL1] [RL12]
  // operand fields differ per form: pair byte, src-then-dst, or dst-then-immediate
  assign dst_addr = (op == exec_pkg::OP_SUB_RR || op == exec_pkg::OP_SUB_RIR)
    ? work_addr(b1[7:4], window_base_first, window_base_second)
    : (op == exec_pkg::OP_SUB_GG || op == exec_pkg::OP_SUB_GI)
    ? resolve(b2, window_base_first, window_base_second)
    : resolve(b1, window_base_first, window_base_second);
  assign src_addr = (op == exec_pkg::OP_SUB_RR || op == exec_pkg::OP_SUB_RIR)
    ? work_addr(b1[3:0], window_base_first, window_base_second)
    : resolve(b1, window_base_first, window_base_second);

  // register array ports
  assign idle = (state == exec_pkg::S_IDLE);
  assign do_exec = (state == exec_pkg::S_EXEC);
  assign bus.ra_addr = do_exec ? eff_dst : dst_addr;
  assign bus.rb_addr = do_exec ? eff_src : src_addr;
  assign bus.rc_addr = paddr[9:2];
  assign rd_a = overlay(bus.ra_addr, bus.ra_data, window_base_first, window_base_second); // [RL6]
  assign rd_b = overlay(bus.rb_addr, bus.rb_data, window_base_first, window_base_second); // [RL6]
  assign rd_c = overlay(bus.rc_addr, bus.rc_data, window_base_first, window_base_second); // [RL6]
  assign opb = src_imm ? b2 : rd_b;

  // alu feed
  assign bus.alu_op = is_sub ? exec_pkg::ALU_SUB : is_sra ? exec_pkg::ALU_SRA : exec_pkg::ALU_PASS;
  assign bus.alu_a = rd_a;
  assign bus.alu_b = opb;
  assign bus.flags_in = flags;

  // apb access decode; writes only land while idle, so stop freezes everything
  logic acc, rf_hit, unmapped, apb_we, exec_we, start, ptr_a_hit, ptr_b_hit;
  logic [7:0] apb_addr;
  assign acc = psel & penable & pready;
  assign rf_hit = (paddr < exec_pkg::OFF_INSTR);
  assign unmapped = (paddr[1:0] != 2'h0) || (!rf_hit && paddr != exec_pkg::OFF_INSTR
    && paddr != exec_pkg::OFF_FLAGS && paddr != exec_pkg::OFF_STATUS);
  assign refuse = unmapped || (pwrite && !idle); // [RL8]
  assign apb_we = acc & pwrite & ~pslverr;
  assign apb_addr = paddr[9:2];
  assign start = apb_we && (paddr == exec_pkg::OFF_INSTR);
  assign exec_we = do_exec && (is_sub || is_sra);
  assign ptr_a_hit = (bus.wr_addr == exec_pkg::ADDR_PTR_A);
  assign ptr_b_hit = (bus.wr_addr == exec_pkg::ADDR_PTR_B);
  assign bus.wr_addr = do_exec ? eff_dst : apb_addr; // [RL16]
  assign bus.wr_data = do_exec ? bus.alu_res : pwdata[7:0];
  assign bus.wr_en = (exec_we || (apb_we && rf_hit)) && !ptr_a_hit && !ptr_b_hit;

  // apb answer: data and ready one cycle after setup, so every output is a flop
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= psel & ~penable & ~pready;
      pslverr <= psel & ~penable & refuse;
      if (psel & ~penable)
      begin
        prdata <= rf_hit ? {24'h00_0000, rd_c}
          : (paddr == exec_pkg::OFF_INSTR) ? {8'h00, instr}
          : (paddr == exec_pkg::OFF_FLAGS) ? {24'h00_0000, flags}
          : (paddr == exec_pkg::OFF_STATUS) ? {29'h0000_0000, illegal, stop_mode, ~idle & ~stop_mode}
          : 32'h0000_0000;
      end
    end
  end

  // interrupt pin synchroniser
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      int_meta <= 1'b0;
      int_sync <= 1'b0;
    end
    else
    begin
      int_meta <= ext_int;
      int_sync <= int_meta;
    end
  end

  // sequencer: resolve indirect addresses, execute, then pad to the documented length
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= exec_pkg::S_IDLE;
      cnt <= 3'h0;
      eff_dst <= 8'h00;
      eff_src <= 8'h00;
      stop_mode <= 1'b0;
      cpu_clk_en <= 1'b1;
      sys_clk_en <= 1'b1;
    end
    else
    begin
      cnt <= cnt + 3'h1;
      case (state)
        exec_pkg::S_IDLE:
        begin
          cnt <= 3'h1;
          if (start)
          begin
            state <= exec_pkg::S_RESOLVE;
          end
        end
        exec_pkg::S_RESOLVE:
        begin
          eff_dst <= dst_ind ? rd_a : dst_addr; // [RL16]
          eff_src <= src_ind ? rd_b : src_addr; // [RL16]
          state <= exec_pkg::S_EXEC;
        end
        exec_pkg::S_EXEC:
        begin
          state <= exec_pkg::S_WAIT;
        end
        exec_pkg::S_WAIT:
        begin
          if (cnt == 3'(ncyc - 3'h1))
          begin
            if (op == exec_pkg::OP_STOP)
            begin
              state <= exec_pkg::S_STOP; // [RL7]
              stop_mode <= 1'b1;
              cpu_clk_en <= 1'b0;
              sys_clk_en <= 1'b0;
            end
            else
            begin
              state <= exec_pkg::S_IDLE;
            end
          end
        end
        exec_pkg::S_STOP:
        begin
          // only the pin wakes it; reset acts through presetn
          if (int_sync) // [RL9]
          begin
            state <= exec_pkg::S_IDLE;
            stop_mode <= 1'b0;
            cpu_clk_en <= 1'b1;
            sys_clk_en <= 1'b1;
          end
        end
        default:
        begin
          state <= exec_pkg::S_IDLE;
        end
      endcase
    end
  end

  // instruction, flags and illegal marker
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      instr <= 24'h00_0000;
      flags <= exec_pkg::FLAGS_RESET;
      illegal <= 1'b0;
    end
    else
    begin
      if (start)
      begin
        instr <= pwdata[23:0];
        illegal <= 1'b0;
      end
      if (apb_we && paddr == exec_pkg::OFF_FLAGS)
      begin
        flags <= pwdata[7:0];
      end
      if (do_exec)
      begin
        if (op == exec_pkg::OP_CARRY_FORCE)
        begin
          flags <= flags | exec_pkg::FLAG_C_MASK; // [RL1]
        end
        else if (is_sub || is_sra)
        begin
          flags <= bus.flags_out; // [RL3] [RL13] [RL14] [RL15]
        end
        else if (op != exec_pkg::OP_PTR_LOAD && op != exec_pkg::OP_STOP)
        begin
          illegal <= 1'b1;
        end
      end
    end
  end

  // window bases: written by pointer load, by result write-back or by apb
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      window_base_first <= exec_pkg::PTR_RESET;
      window_base_second <= exec_pkg::PTR_RESET;
    end
    else if (do_exec && op == exec_pkg::OP_PTR_LOAD)
    begin
      case (b1[1:0])
        exec_pkg::SEL_PTR_A: window_base_first[7:3] <= b1[7:3]; // [RL4]
        exec_pkg::SEL_PTR_B: window_base_second[7:3] <= b1[7:3]; // [RL4]
        exec_pkg::SEL_PTR_BOTH:
        begin
          window_base_first[7:3] <= {b1[7:4], 1'b0}; // [RL5]
          window_base_second[7:3] <= {b1[7:4], 1'b1}; // [RL5]
        end
        default: window_base_first <= window_base_first;
      endcase
    end
    else if (exec_we || (apb_we && rf_hit))
    begin
      if (ptr_a_hit)
      begin
        window_base_first <= bus.wr_data; // [RL6]
      end
      if (ptr_b_hit)
      begin
        window_base_second <= bus.wr_data; // [RL6]
      end
    end
  end

  // checks
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [7:0] opb_chk;
  assign opb_chk = opb;

  property p_carry_force;
    do_exec && op == exec_pkg::OP_CARRY_FORCE |=> flags == ($past(flags) | exec_pkg::FLAG_C_MASK);
  endproperty
  a_carry_force: assert property (p_carry_force) else $error("carry force flags wrong"); // [RL1]

  property p_short_len;
    state == exec_pkg::S_RESOLVE && ncyc == exec_pkg::CYC_SHORT && op != exec_pkg::OP_STOP
      |-> ##3 state == exec_pkg::S_IDLE;
  endproperty
  a_short_len: assert property (p_short_len) else $error("short instruction length wrong"); // [RL1]

  property p_sra_result;
    do_exec && is_sra |-> bus.wr_en && bus.wr_data == {rd_a[7], rd_a[7:1]} && bus.wr_addr == eff_dst;
  endproperty
  a_sra_result: assert property (p_sra_result) else $error("shift result wrong"); // [RL2]

  property p_sra_flags;
    do_exec && is_sra |=> flags[exec_pkg::F_C] == $past(rd_a[0]) && !flags[exec_pkg::F_V]
      && flags[exec_pkg::F_D] == $past(flags[exec_pkg::F_D]) && flags[exec_pkg::F_H] == $past(flags[exec_pkg::F_H]);
  endproperty
  a_sra_flags: assert property (p_sra_flags) else $error("shift flags wrong"); // [RL3]

  property p_ptr_one;
    do_exec && op == exec_pkg::OP_PTR_LOAD && b1[1:0] == exec_pkg::SEL_PTR_A
      |=> window_base_first[7:3] == $past(b1[7:3]) && $stable(window_base_second) && $stable(flags);
  endproperty
  a_ptr_one: assert property (p_ptr_one) else $error("first base load wrong"); // [RL4]

  property p_ptr_both;
    do_exec && op == exec_pkg::OP_PTR_LOAD && b1[1:0] == exec_pkg::SEL_PTR_BOTH
      |=> window_base_first[7:3] == {$past(b1[7:4]), 1'b0}
      && window_base_second[7:3] == {$past(b1[7:4]), 1'b1} && $stable(flags);
  endproperty
  a_ptr_both: assert property (p_ptr_both) else $error("both base load wrong"); // [RL5]

  property p_stop_enter;
    state == exec_pkg::S_RESOLVE && op == exec_pkg::OP_STOP |-> ##3 stop_mode && !cpu_clk_en && !sys_clk_en;
  endproperty
  a_stop_enter: assert property (p_stop_enter) else $error("stop not entered on time"); // [RL7]

  property p_stop_keep;
    stop_mode |-> !bus.wr_en ##1 $stable(window_base_first) && $stable(window_base_second) && $stable(flags);
  endproperty
  a_stop_keep: assert property (p_stop_keep) else $error("state changed in stop"); // [RL8]

  property p_stop_exit;
    stop_mode && !int_sync |=> stop_mode;
  endproperty
  a_stop_exit: assert property (p_stop_exit) else $error("stop left without wake"); // [RL9]

  property p_sub_result;
    do_exec && is_sub |-> bus.wr_en && bus.wr_data == 8'(rd_a - opb_chk)
      ##1 flags[exec_pkg::F_Z] == ($past(8'(rd_a - opb_chk)) == 8'h00);
  endproperty
  a_sub_result: assert property (p_sub_result) else $error("subtract result wrong"); // [RL12]

  property p_sub_carry;
    do_exec && is_sub |=> flags[exec_pkg::F_C] == ($past(rd_a) < $past(opb_chk))
      && flags[exec_pkg::F_S] == $past(bus.wr_data[7]);
  endproperty
  a_sub_carry: assert property (p_sub_carry) else $error("subtract carry or sign wrong"); // [RL13]

  property p_sub_v;
    do_exec && is_sub |=> flags[exec_pkg::F_V]
      == ($past(rd_a[7] != opb_chk[7]) && $past(bus.wr_data[7] == opb_chk[7]));
  endproperty
  a_sub_v: assert property (p_sub_v) else $error("subtract overflow wrong"); // [RL14]

  property p_sub_dh;
    do_exec && is_sub |=> flags[exec_pkg::F_D] && flags[exec_pkg::F_H] == $past(rd_a[3:0] < opb_chk[3:0]);
  endproperty
  a_sub_dh: assert property (p_sub_dh) else $error("subtract d or h wrong"); // [RL15]

  property p_long_len;
    state == exec_pkg::S_RESOLVE && ncyc == exec_pkg::CYC_LONG |-> ##5 state == exec_pkg::S_IDLE;
  endproperty
  a_long_len: assert property (p_long_len) else $error("long instruction length wrong"); // [RL12]

  property p_indirect;
    state == exec_pkg::S_RESOLVE && src_ind |=> eff_src == $past(rd_b);
  endproperty
  a_indirect: assert property (p_indirect) else $error("indirect source address wrong"); // [RL16]
endmodule : exec_core

// >>> hw/exec_if.sv
// Purpose: carrier between the core, its register array and its alu
// Assumes: one clock domain
// Notes: read ports are combinational
`timescale 1ns/1ps
interface exec_if;
  logic [7:0] ra_addr, rb_addr, rc_addr, ra_data, rb_data, rc_data;
  logic [7:0] wr_addr, wr_data;
  logic wr_en;
  exec_pkg::alu_op_t alu_op;
  logic [7:0] alu_a, alu_b, flags_in, alu_res, flags_out;
  modport core (output ra_addr, rb_addr, rc_addr, wr_addr, wr_data, wr_en, alu_op, alu_a, alu_b, flags_in,
    input ra_data, rb_data, rc_data, alu_res, flags_out);
  modport mem (input ra_addr, rb_addr, rc_addr, wr_addr, wr_data, wr_en, output ra_data, rb_data, rc_data);
  modport alu (input alu_op, alu_a, alu_b, flags_in, output alu_res, flags_out);
endinterface : exec_if

// >>> hw/exec_pkg.sv
// Purpose: shared constants for the small instruction execution core
// Assumes: apb register bus, 32-bit data, one register per aligned word
// Notes:
// Operation
// (RL1) The carry-force opcode sets carry to one, leaves all other flags alone and takes four cycles.
// (RL2) The arithmetic right shift moves every bit one place down while bit 7 stays and is also copied to bit 6.
// (RL3) After the shift carry takes the old bit 0, zero and sign follow the result, overflow clears, D and H stay.
// (RL4) Pointer load with source bits 1:0 of 10 writes bits 7:3 to the first window base, 01 to the second.
// (RL5) Pointer load with bits 1:0 of 00 copies bits 7:4 to both bases, bit 3 cleared in the first, set in the second.
// (RL6) The two window bases sit at register addresses d6 and d7 and read like any register.
// (RL7) The stop opcode takes four cycles, then gates the cpu and system clocks and enters stop.
// (RL8) While stopped, every register keeps its contents.
// (RL9) Stop is left only by an external reset or an external interrupt.
// (RL10) Whoever wakes the device by reset holds reset low until the oscillator has settled.
// (RL11) Software follows the stop opcode with at least three idle_op instructions.
// (RL12) Subtract writes destination minus source to the destination; register pair form 4 cycles, others 6.
// (RL13) After subtract carry marks a borrow, zero a zero result, sign a negative result.
// (RL14) Subtract sets overflow only when the operand signs differ and the result sign equals the source sign.
// (RL15) Subtract sets D to one and sets H on a borrow out of the low nibble, clearing it on a carry.
// (RL16) Indirect operand forms read and write the register whose address the named register holds.
package exec_pkg;
  // opcodes
  localparam logic [7:0] OP_CARRY_FORCE = 8'hdf;
  localparam logic [7:0] OP_SHIFT_R = 8'hd0;
  localparam logic [7:0] OP_SHIFT_IR = 8'hd1;
  localparam logic [7:0] OP_PTR_LOAD = 8'h31;
  localparam logic [7:0] OP_STOP = 8'h7f;
  localparam logic [7:0] OP_SUB_RR = 8'h22;
  localparam logic [7:0] OP_SUB_RIR = 8'h23;
  localparam logic [7:0] OP_SUB_GG = 8'h24;
  localparam logic [7:0] OP_SUB_GI = 8'h25;
  localparam logic [7:0] OP_SUB_IM = 8'h26;
  // register space
  localparam logic [7:0] ADDR_PTR_A = 8'hd6;
  localparam logic [7:0] ADDR_PTR_B = 8'hd7;
  localparam logic [3:0] WORK_NIB = 4'hc;
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [1:0] SEL_PTR_A = 2'h2;
  localparam logic [1:0] SEL_PTR_B = 2'h1;
  localparam logic [1:0] SEL_PTR_BOTH = 2'h0;
  // instruction lengths in clocks
  localparam logic [2:0] CYC_SHORT = 3'h4;
  localparam logic [2:0] CYC_LONG = 3'h6;
  // flag positions
  localparam int F_C = 7;
  localparam int F_Z = 6;
  localparam int F_S = 5;
  localparam int F_V = 4;
  localparam int F_D = 3;
  localparam int F_H = 2;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] FLAG_C_MASK = 8'h80;
  // apb map
  localparam int AW = 12;
  localparam logic [11:0] OFF_INSTR = 12'h400;
  localparam logic [11:0] OFF_FLAGS = 12'h404;
  localparam logic [11:0] OFF_STATUS = 12'h408;
  localparam int ST_BUSY = 0;
  localparam int ST_STOP = 1;
  localparam int ST_ILL = 2;
  typedef enum logic [1:0] {ALU_PASS = 2'h0, ALU_SRA = 2'h1, ALU_SUB = 2'h2} alu_op_t;
  typedef enum logic [4:0] {
    S_IDLE = 5'h01, S_RESOLVE = 5'h02, S_EXEC = 5'h04, S_WAIT = 5'h08, S_STOP = 5'h10
  } state_t;
endpackage : exec_pkg

// >>> hw/exec_regfile.sv
// Purpose: 256 byte register array, three read ports, one write port
// Assumes: write gated by the core
// Notes: no reset, contents survive stop
`timescale 1ns/1ps
module exec_regfile (
  input wire logic pclk,
  exec_if.mem bus
);
  logic [7:0] mem [256];
  // reads are combinational so an operand is ready in its own cycle
  assign bus.ra_data = mem[bus.ra_addr];
  assign bus.rb_data = mem[bus.rb_addr];
  assign bus.rc_data = mem[bus.rc_addr];
  // single write port
  always_ff @(posedge pclk)
  begin
    if (bus.wr_en)
    begin
      mem[bus.wr_addr] <= bus.wr_data;
    end
  end
endmodule : exec_regfile

// >>> verification/exec_core_tb.sv
// Purpose: self-checking bench for the instruction execution core
// Assumes: apb answers after one access cycle, one idle cycle between transfers
// Notes: busy length is judged by how many spaced status reads it survives
`timescale 1ns/1ps
module cpu_instr_set_carry_to_subtract_tb;
  logic pclk, presetn, psel, penable, pwrite, ext_int, pready, pslverr, stop_mode, cpu_clk_en, sys_clk_en, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  int failures, compares;
  exec_core exec_core_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_int(ext_int),
    .stop_mode(stop_mode), .cpu_clk_en(cpu_clk_en), .sys_clk_en(sys_clk_en));
  // 125 mhz clock
  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  // counts, verdict, end of run
  task automatic wrap_up;
    $display("failures=%0d compares=%0d", failures, compares);
    if (failures == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk
  // one transfer plus an idle cycle, so no setup is driven twice in one step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      failures++;
      wrap_up();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  function automatic logic [11:0] ra(input logic [7:0] a);
    return {2'b00, a, 2'b00};
  endfunction : ra
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, ra(a), {24'h000000, d});
  endtask : wreg
  task automatic rc(input logic [11:0] a, input logic [7:0] exp, input string what);
    apb(1'b0, a, 32'h00000000);
    chk(q, {24'h000000, exp}, what);
  endtask : rc
  // start one instruction and count status reads until busy drops or stop shows
  task automatic run(input logic [23:0] ins, input int reads);
    int k;
    apb(1'b1, exec_pkg::OFF_INSTR, {8'h00, ins});
    k = 0;
    do
    begin
      apb(1'b0, exec_pkg::OFF_STATUS, 32'h00000000);
      k++;
    end
    while (q[exec_pkg::ST_BUSY] !== 1'b0 && q[exec_pkg::ST_STOP] !== 1'b1 && k < 40);
    if (k >= 40)
    begin
      failures++;
      wrap_up();
    end
    if (reads > 0)
      chk(32'(k), 32'(reads), "status reads while busy");
  endtask : run
  task automatic t_carry;
    apb(1'b1, exec_pkg::OFF_FLAGS, 32'h0000007f);
    run(24'h0000df, 2);
    rc(exec_pkg::OFF_FLAGS, 8'hff, "flags after carry force");
  endtask : t_carry
  task automatic t_shift;
    wreg(8'h10, 8'h9a);
    apb(1'b1, exec_pkg::OFF_FLAGS, 32'h0000009c);
    run(24'h0010d0, 2);
    rc(ra(8'h10), 8'hcd, "shift result");
    rc(exec_pkg::OFF_FLAGS, 8'h2c, "shift flags");
    wreg(8'h11, 8'h01);
    apb(1'b1, exec_pkg::OFF_FLAGS, 32'h00000000);
    run(24'h0011d0, 2);
    rc(exec_pkg::OFF_FLAGS, 8'hc0, "shift to zero flags");
    wreg(8'h12, 8'h13);
    wreg(8'h13, 8'hbc);
    run(24'h0012d1, 2);
    rc(ra(8'h13), 8'hde, "indirect shift target");
    rc(ra(8'h12), 8'h13, "indirect pointer kept");
  endtask : t_shift
  task automatic t_ptr;
    apb(1'b1, exec_pkg::OFF_FLAGS, 32'h000000a4);
    run(24'h004031, 2);
    rc(ra(exec_pkg::ADDR_PTR_A), 8'h40, "both load first");
    rc(ra(exec_pkg::ADDR_PTR_B), 8'h48, "both load second");
    run(24'h005231, 2);
    run(24'h006931, 2);
    rc(ra(exec_pkg::ADDR_PTR_A), 8'h50, "first only");
    rc(ra(exec_pkg::ADDR_PTR_B), 8'h68, "second only");
    rc(exec_pkg::OFF_FLAGS, 8'ha4, "flags kept by pointer load");
  endtask : t_ptr
  // immediate form: dst, imm, result, flags
  task automatic t_sub;
    logic [31:0] tv [4] = '{32'h219091b8, 32'h2165bcac, 32'h21210048, 32'h80017f1c};
    foreach (tv[i])
    begin
      wreg(8'h01, tv[i][31:24]);
      run({tv[i][23:16], 8'h01, exec_pkg::OP_SUB_IM}, 3);
      rc(ra(8'h01), tv[i][15:8], "sub immediate result");
      rc(exec_pkg::OFF_FLAGS, tv[i][7:0], "sub flags");
    end
    wreg(8'h02, 8'h03);
    wreg(8'h01, 8'h21);
    run(24'h010224, 3);
    rc(ra(8'h01), 8'h1e, "sub register result");
    rc(ra(8'h02), 8'h03, "sub source kept");
    rc(exec_pkg::OFF_FLAGS, 8'h0c, "sub borrow flags");
    wreg(8'h03, 8'h0a);
    wreg(8'h01, 8'h21);
    run(24'h010225, 3);
    rc(ra(8'h01), 8'h17, "sub indirect source");
    wreg(8'h51, 8'h12);
    wreg(8'h52, 8'h03);
    run(24'h001222, 2);
    rc(ra(8'h51), 8'h0f, "sub working pair");
  endtask : t_sub
  // stop, refused write, retention, wake by interrupt and by reset
  task automatic t_stop;
    int n;
    wreg(8'h20, 8'h5a);
    run({16'h0000, exec_pkg::OP_STOP}, 0);
    chk({29'h0, stop_mode, cpu_clk_en, sys_clk_en}, 32'h4, "stop entry pins");
    wreg(8'h20, 8'hff);
    chk({31'h0, e}, 32'h1, "write refused while stopped");
    rc(ra(8'h20), 8'h5a, "array kept in stop");
    rc(ra(exec_pkg::ADDR_PTR_A), 8'h50, "pointer kept in stop");
    repeat (20) @(posedge pclk);
    chk({31'h0, stop_mode}, 32'h1, "no wake without cause");
    ext_int <= 1'b1;
    n = 0;
    while (stop_mode !== 1'b0 && n < 10)
    begin
      @(posedge pclk);
      n++;
    end
    ext_int <= 1'b0;
    chk({30'h0, cpu_clk_en, sys_clk_en}, 32'h3, "clocks back after interrupt");
    // idle for twelve clocks, three four-clock idle_op times, before the next instruction
    repeat (12) @(posedge pclk);
    run({16'h0000, exec_pkg::OP_STOP}, 0);
    presetn <= 1'b0;
    @(posedge pclk);
    #1;
    chk({31'h0, stop_mode}, 32'h0, "reset leaves stop");
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask : t_stop
  task automatic t_map;
    rc(12'h40c, 8'h00, "unmapped read data");
    chk({31'h0, e}, 32'h1, "unmapped read error");
    rc(12'h402, 8'h00, "unaligned read data");
    chk({31'h0, e}, 32'h1, "unaligned read error");
    run(24'h000001, 2);
    chk({31'h0, q[exec_pkg::ST_ILL]}, 32'h1, "unknown opcode marked");
  endtask : t_map
  // reset, then each scenario in turn
  initial
  begin
    {psel, penable, pwrite, ext_int, presetn} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    failures = 0;
    compares = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rc(ra(exec_pkg::ADDR_PTR_B), exec_pkg::PTR_RESET, "pointer reset value");
    t_carry();
    t_shift();
    t_ptr();
    t_sub();
    t_stop();
    t_map();
    wrap_up();
  end
endmodule : cpu_instr_set_carry_to_subtract_tb
